/* File: src/sio_indicators.sv */
// Status indicator encoder for the safety I/O module lamps.
// Assumes all condition inputs are synchronous to clock_i.
//
// Notes on behaviour
// - Lock lamp dark without, with invalid, or originator-made configuration.
// - Lock lamp steady yellow when valid configuration is locked.
// - Lock lamp flashes yellow when valid tool configuration is unlocked.
// - Power lamp dark without field power, green within limits, else yellow.
// - With sensor power used, sensor over or no current also gives yellow.
// - Sensor lamp dark unused, green used, red on current fault.
// - Analog lamp dark when unused or configuring, yellow when fault free.
// - Analog lamp steady red on own signal path fault.
// - Analog lamp flashes red on partner path fault in dual pairing.
// - Tachometer lamp dark below off threshold, yellow above on threshold.
// - Tachometer lamp steady above 30 Hz, follows signal below it.
// - Digital input lamp dark when off or configuring, yellow when on.
// - Digital input lamp steady red on wiring or own circuit fault.
// - Digital input lamp flashes red on partner circuit fault.
// - Digital output lamp dark when off or configuring, yellow when on.
// - Digital output lamp steady red on own output circuit fault.
// - Dual output pair shows steady red when commanded values differ.
// - Digital output lamp flashes red on partner circuit fault in dual pairing.
`timescale 1ns/1ps
`default_nettype none
`include "sio_cfg.svh"
module sio_indicators #(
    parameter int NSEN = `SIO_NSEN,
    parameter int NAIN = `SIO_NAIN,
    parameter int NDIN = `SIO_NDIN,
    parameter int NDOUT = `SIO_NDOUT,
    parameter int unsigned BLINK_HALF_CYC = `SIO_BLINK_HALF_CYC,
    parameter int unsigned TACH_HOLD_CYC = `SIO_TACH_HOLD_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Configuration state
    input wire logic cfg_present_i,
    input wire logic cfg_valid_i,
    input wire logic cfg_by_originator_i,
    input wire logic cfg_locked_i,
    input wire logic configuring_i,
    // Field and sensor power monitors
    input wire logic field_pwr_present_i,
    input wire logic field_pwr_in_limits_i,
    input wire logic [NSEN-1:0] sensor_pwr_used_i,
    input wire logic [NSEN-1:0] sensor_over_i,
    input wire logic [NSEN-1:0] sensor_under_i,
    // Analog input channels
    input wire logic [NAIN-1:0] ain_used_i,
    input wire logic [NAIN-1:0] ain_fault_i,
    input wire logic [NAIN-1:0] ain_partner_fault_i,
    input wire logic [NAIN-1:0] ain_tach_mode_i,
    input wire logic [NAIN-1:0] ain_tach_above_on_i,
    input wire logic [NAIN-1:0] ain_tach_below_off_i,
    // Digital input channels
    input wire logic [NDIN-1:0] din_on_i,
    input wire logic [NDIN-1:0] din_fault_i,
    input wire logic [NDIN-1:0] din_partner_fault_i,
    // Digital output channels
    input wire logic [NDOUT-1:0] dout_cmd_i,
    input wire logic [NDOUT-1:0] dout_fault_i,
    input wire logic [NDOUT-1:0] dout_partner_fault_i,
    input wire logic [NDOUT/2-1:0] dout_dual_i,
    // Indicator drivers
    output var sio_pkg::sio_color_e config_lock_indicator_o,
    output var sio_pkg::sio_color_e field_power_indicator_o,
    output wire sio_pkg::sio_color_e [NSEN-1:0] sensor_supply_indicators_o,
    output wire sio_pkg::sio_color_e [NAIN-1:0] ain_indicator_o,
    output wire sio_pkg::sio_color_e [NDIN-1:0] din_indicator_o,
    output wire sio_pkg::sio_color_e [NDOUT-1:0] dout_indicator_o
);
    import sio_pkg::*;

    localparam int AI_BASE = NSEN;
    localparam int DI_BASE = NSEN + NAIN;
    localparam int DO_BASE = NSEN + NAIN + NDIN;
    localparam int NCH = DO_BASE + NDOUT;
    localparam int TW = $clog2(TACH_HOLD_CYC + 1);

    sio_blink_if blink_if ();
    sio_color_e [NCH-1:0] lamp_q;
    logic [NAIN-1:0] tach_lamp_q;
    logic sensor_bad;

    // Single timebase, so every flashing lamp stays in step
    sio_blink #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .blink(blink_if.drv)
    );

    // Configuration lock lamp
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            config_lock_indicator_o <= SIO_OFF;
        end else if (!cfg_present_i || !cfg_valid_i || cfg_by_originator_i) begin
            config_lock_indicator_o <= SIO_OFF;
        end else if (cfg_locked_i) begin
            config_lock_indicator_o <= SIO_YELLOW;
        end else begin
            config_lock_indicator_o <= blink_if.phase ? SIO_YELLOW : SIO_OFF;
        end
    end

    // Any used sensor supply out of range pulls the power lamp to yellow while field power is present
    assign sensor_bad = |(sensor_pwr_used_i & (sensor_over_i | sensor_under_i));

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            field_power_indicator_o <= SIO_OFF;
        end else if (!field_pwr_present_i) begin
            field_power_indicator_o <= SIO_OFF;
        end else if (!field_pwr_in_limits_i || sensor_bad) begin
            field_power_indicator_o <= SIO_YELLOW;
        end else begin
            field_power_indicator_o <= SIO_GREEN;
        end
    end

    // One lamp slot per channel: sensor, analog, digital in, digital out
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic act;
        logic own;
        logic par;
        sio_color_e on_col;
        sio_color_e col;

        if (g < AI_BASE) begin : g_sen
            assign act = sensor_pwr_used_i[g];
            assign own = sensor_pwr_used_i[g] && (sensor_over_i[g] || sensor_under_i[g]);
            assign par = 1'b0;
            assign on_col = SIO_GREEN;
        end else if (g < DI_BASE) begin : g_ain
            localparam int K = g - AI_BASE;
            logic [TW-1:0] hold_q;
            // The hold bridges off phases shorter than one period at the
            // steady rate; slower signals show through as a yellow flash.
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    hold_q <= '0;
                end else if (ain_tach_above_on_i[K]) begin
                    hold_q <= TW'(TACH_HOLD_CYC);
                end else if (hold_q != '0) begin
                    hold_q <= hold_q - TW'(1);
                end
            end
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    tach_lamp_q[K] <= 1'b0;
                end else if (ain_tach_above_on_i[K]) begin
                    tach_lamp_q[K] <= 1'b1;
                end else if (ain_tach_below_off_i[K] && hold_q == '0) begin
                    tach_lamp_q[K] <= 1'b0;
                end
            end
            assign act = ain_used_i[K] && !configuring_i
                && (!ain_tach_mode_i[K] || tach_lamp_q[K]);
            assign own = ain_fault_i[K];
            assign par = ain_partner_fault_i[K];
            assign on_col = SIO_YELLOW;
        end else if (g < DO_BASE) begin : g_din
            localparam int K = g - DI_BASE;
            assign act = din_on_i[K] && !configuring_i;
            assign own = din_fault_i[K];
            assign par = din_partner_fault_i[K];
            assign on_col = SIO_YELLOW;
        end else begin : g_dout
            localparam int K = g - DO_BASE;
            logic mis;
            // Both lamps of a dual pair go red while commands disagree
            assign mis = dout_dual_i[K/2] && (dout_cmd_i[K] != dout_cmd_i[K^1]);
            assign act = dout_cmd_i[K] && !configuring_i;
            assign own = dout_fault_i[K] || mis;
            assign par = dout_partner_fault_i[K] && dout_dual_i[K/2];
            assign on_col = SIO_YELLOW;
        end

        sio_lamp_enc u_enc (
            .active_i(act),
            .own_fault_i(own),
            .partner_fault_i(par),
            .on_color_i(on_col),
            .phase_i(blink_if.phase),
            .color_o(col)
        );

        always_ff @(posedge clock_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                lamp_q[g] <= SIO_OFF;
            end else begin
                lamp_q[g] <= col;
            end
        end
    end

    assign sensor_supply_indicators_o = lamp_q[AI_BASE-1:0];
    assign ain_indicator_o = lamp_q[DI_BASE-1:AI_BASE];
    assign din_indicator_o = lamp_q[DO_BASE-1:DI_BASE];
    assign dout_indicator_o = lamp_q[NCH-1:DO_BASE];

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    logic lock_ok;
    logic ain0_clean;
    assign lock_ok = cfg_present_i && cfg_valid_i && !cfg_by_originator_i;
    assign ain0_clean = ain_used_i[0] && ain_tach_mode_i[0] && !configuring_i
        && !ain_fault_i[0] && !ain_partner_fault_i[0];

    property p_lock_off;
        !lock_ok |=> config_lock_indicator_o == SIO_OFF;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock lamp lit");

    property p_lock_solid;
        lock_ok && cfg_locked_i |=> config_lock_indicator_o == SIO_YELLOW;
    endproperty
    a_lock_solid: assert property (p_lock_solid) else $error("lock lamp not solid");

    property p_lock_flash;
        lock_ok && !cfg_locked_i && !blink_if.phase ##1 lock_ok && !cfg_locked_i
            |-> config_lock_indicator_o == SIO_OFF;
    endproperty
    a_lock_flash: assert property (p_lock_flash) else $error("lock lamp not flashing");

    property p_pwr;
        field_pwr_present_i && field_pwr_in_limits_i && !sensor_bad
            |=> field_power_indicator_o == SIO_GREEN;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power lamp not green");

    property p_pwr_sensor;
        field_pwr_present_i && sensor_bad |=> field_power_indicator_o == SIO_YELLOW;
    endproperty
    a_pwr_sensor: assert property (p_pwr_sensor) else $error("sensor fault not shown");

    property p_sensor;
        sensor_pwr_used_i[0] && sensor_over_i[0]
            |=> sensor_supply_indicators_o[0] == SIO_RED;
    endproperty
    a_sensor: assert property (p_sensor) else $error("sensor lamp not red");

    property p_ain_red;
        ain_fault_i[0] |=> ain_indicator_o[0] == SIO_RED;
    endproperty
    a_ain_red: assert property (p_ain_red) else $error("analog lamp not red");

    property p_tach_hold;
        ain0_clean && ain_tach_above_on_i[0] ##1 ain0_clean [*2]
            |=> ain_indicator_o[0] == SIO_YELLOW;
    endproperty
    a_tach_hold: assert property (p_tach_hold) else $error("tach lamp dropped");

    property p_din_partner;
        !din_fault_i[1] && din_partner_fault_i[1] && !blink_if.phase
            |=> din_indicator_o[1] == SIO_OFF;
    endproperty
    a_din_partner: assert property (p_din_partner) else $error("partner lamp not dark");

    property p_dout_mismatch;
        dout_dual_i[0] && (dout_cmd_i[0] != dout_cmd_i[1])
            |=> dout_indicator_o[0] == SIO_RED && dout_indicator_o[1] == SIO_RED;
    endproperty
    a_dout_mismatch: assert property (p_dout_mismatch) else $error("pair mismatch hidden");

    property p_ain_dark;
        (!ain_used_i[1] || configuring_i) && !ain_fault_i[1] && !ain_partner_fault_i[1]
            |=> ain_indicator_o[1] == SIO_OFF;
    endproperty
    a_ain_dark: assert property (p_ain_dark) else $error("analog lamp not dark");

    property p_ain_partner;
        !ain_fault_i[2] && ain_partner_fault_i[2] && blink_if.phase
            |=> ain_indicator_o[2] == SIO_RED;
    endproperty
    a_ain_partner: assert property (p_ain_partner) else $error("analog flash not red");

    property p_tach_on;
        ain0_clean && ain_tach_above_on_i[0] ##1 ain0_clean |=> ain_indicator_o[0] == SIO_YELLOW;
    endproperty
    a_tach_on: assert property (p_tach_on) else $error("tach lamp not lit");

    property p_din_on;
        din_on_i[2] && !configuring_i && !din_fault_i[2] && !din_partner_fault_i[2]
            |=> din_indicator_o[2] == SIO_YELLOW;
    endproperty
    a_din_on: assert property (p_din_on) else $error("input lamp not yellow");

    property p_din_red;
        din_fault_i[4] |=> din_indicator_o[4] == SIO_RED;
    endproperty
    a_din_red: assert property (p_din_red) else $error("input lamp not red");

    property p_dout_on;
        dout_cmd_i[5] && !configuring_i && !dout_fault_i[5] && !dout_dual_i[2]
            |=> dout_indicator_o[5] == SIO_YELLOW;
    endproperty
    a_dout_on: assert property (p_dout_on) else $error("output lamp not yellow");

    property p_dout_red;
        dout_fault_i[6] |=> dout_indicator_o[6] == SIO_RED;
    endproperty
    a_dout_red: assert property (p_dout_red) else $error("output lamp not red");

    property p_dout_partner;
        !dout_fault_i[7] && dout_partner_fault_i[7] && dout_dual_i[3]
            && dout_cmd_i[6] == dout_cmd_i[7] && blink_if.phase
            |=> dout_indicator_o[7] == SIO_RED;
    endproperty
    a_dout_partner: assert property (p_dout_partner) else $error("output flash not red");

    // Own fault must win even while the partner also reports one
    property p_priority;
        din_fault_i[5] && din_partner_fault_i[5] |=> din_indicator_o[5] == SIO_RED;
    endproperty
    a_priority: assert property (p_priority) else $error("own fault not steady");

    c_lock_flash: cover property (lock_ok && !cfg_locked_i ##1 $changed(blink_if.phase));
    c_tach_off: cover property (ain0_clean && $fell(ain_indicator_o[0] == SIO_YELLOW));
    c_dout_mis: cover property (dout_dual_i[0] && dout_cmd_i[0] != dout_cmd_i[1]);
endmodule
`default_nettype wire

/* File: src/sio_cfg.svh */
// Timing and sizing constants for the safety I/O status indicator block.
// Assumes a 50 MHz module clock.
`ifndef SIO_CFG_SVH
`define SIO_CFG_SVH

`define SIO_CLK_HZ 50000000
`define SIO_NSEN 4
`define SIO_NAIN 4
`define SIO_NDIN 8
`define SIO_NDOUT 8
// Common blink half period, in milliseconds
`define SIO_BLINK_HALF_MS 250
`define SIO_BLINK_HALF_CYC ((`SIO_CLK_HZ / 1000) * `SIO_BLINK_HALF_MS)
// Tachometer rate above which the lamp stands steady, in hertz
`define SIO_TACH_MIN_HZ 30
`define SIO_TACH_HOLD_CYC (`SIO_CLK_HZ / `SIO_TACH_MIN_HZ)

`endif

/* File: src/sio_pkg.sv */
// Types shared by the safety I/O status indicator block.
// Assumes nothing of its surroundings.
`default_nettype none
package sio_pkg;
    typedef enum logic [1:0] {
        SIO_OFF,
        SIO_YELLOW,
        SIO_GREEN,
        SIO_RED
    } sio_color_e;
endpackage
`default_nettype wire

/* File: src/sio_blink_if.sv */
// Carries the common blink phase from the timebase to the lamp logic.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface sio_blink_if;
    logic phase;
    modport drv (output phase);
    modport use_p (input phase);
endinterface
`default_nettype wire

/* File: src/sio_blink.sv */
// Free running blink timebase shared by every flashing lamp.
// Assumes a synchronous design clock and asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
`include "sio_cfg.svh"
module sio_blink #(
    parameter int unsigned HALF_CYC = `SIO_BLINK_HALF_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Phase out
    sio_blink_if.drv blink
);
    localparam int CW = $clog2(HALF_CYC + 1);
    logic [CW-1:0] cnt_q;
    logic phase_q;

    // Equal on and off halves
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            phase_q <= 1'b0;
        end else if (cnt_q == CW'(HALF_CYC - 1)) begin
            cnt_q <= '0;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign blink.phase = phase_q;
endmodule
`default_nettype wire

/* File: src/sio_lamp_enc.sv */
// Priority encoder for one channel lamp: fault, partner fault, on, off.
// Assumes the blink phase comes from the shared timebase.
`timescale 1ns/1ps
`default_nettype none
module sio_lamp_enc (
    // Channel condition
    input wire logic active_i,
    input wire logic own_fault_i,
    input wire logic partner_fault_i,
    input wire sio_pkg::sio_color_e on_color_i,
    // Blink phase
    input wire logic phase_i,
    // Lamp
    output var sio_pkg::sio_color_e color_o
);
    import sio_pkg::*;

    always_comb begin
        if (own_fault_i) begin
            color_o = SIO_RED;
        end else if (partner_fault_i) begin
            color_o = phase_i ? SIO_RED : SIO_OFF;
        end else if (active_i) begin
            color_o = on_color_i;
        end else begin
            color_o = SIO_OFF;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/sio_lamp_reader.sv */
// Reader of one lamp, standing in for the person who watches it.
// Assumes the lamp colour is synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module sio_lamp_reader (
    // Clock and window restart
    input wire logic clock_i,
    input wire logic clear_i,
    // Lamp under watch
    input wire sio_pkg::sio_color_e lamp_i,
    // What was seen since the restart
    output var logic [7:0] lit_o,
    output var logic [7:0] dark_o,
    output var sio_pkg::sio_color_e hue_o
);
    import sio_pkg::*;
    // A person sees only lit or dark, and the colour while lit
    always_ff @(posedge clock_i) begin
        if (clear_i) begin
            lit_o <= 8'h00;
            dark_o <= 8'h00;
        end else if (lamp_i == SIO_OFF) begin
            dark_o <= dark_o + 8'h01;
        end else begin
            lit_o <= lit_o + 8'h01;
            hue_o <= lamp_i;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/sio_indicators_test.sv */
// Self-checking bench for the status indicator encoder.
// Assumes short blink and tach counts; outputs lag inputs by one edge.
`timescale 1ns/1ps
`default_nettype none
module sio_indicators_test;
    import sio_pkg::*;
    typedef struct packed {
        logic [2:0] kind;
        sio_color_e [7:0] exp;
        logic [7:0] fl;
    } sio_note_s;
    localparam int HALF = 4;
    int seed = 32'hecef9e3d;
    int errors = 0;
    int checks = 0;
    int sel = 0;
    sio_note_s notes[$];
    event look;
    sio_color_e [7:0] ex = {8{SIO_OFF}};
    logic [7:0] fx = 8'h00;
    logic sf;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clear = 1'b0;
    logic cfg_present_i = 1'b0, cfg_valid_i = 1'b0, cfg_by_originator_i = 1'b0;
    logic cfg_locked_i = 1'b0, configuring_i = 1'b0;
    logic field_pwr_present_i = 1'b1, field_pwr_in_limits_i = 1'b1;
    logic [3:0] sensor_pwr_used_i = 4'hf, sensor_over_i = 4'h0, sensor_under_i = 4'h0;
    logic [3:0] ain_used_i = 4'hf, ain_fault_i = 4'h0, ain_partner_fault_i = 4'h0;
    logic [3:0] ain_tach_mode_i = 4'h0, ain_tach_above_on_i = 4'h0, ain_tach_below_off_i = 4'h0;
    logic [7:0] din_on_i = 8'hff, din_fault_i = 8'h00, din_partner_fault_i = 8'h00;
    logic [7:0] dout_cmd_i = 8'hff, dout_fault_i = 8'h00, dout_partner_fault_i = 8'h00;
    logic [3:0] dout_dual_i = 4'h0;
    sio_color_e config_lock_indicator_o, field_power_indicator_o, watch, hue;
    sio_color_e [3:0] sensor_supply_indicators_o, ain_indicator_o;
    sio_color_e [7:0] din_indicator_o, dout_indicator_o;
    logic [7:0] lit, dark;

    sio_indicators #(.BLINK_HALF_CYC(HALF), .TACH_HOLD_CYC(8)) dut (
        .clock_i, .sys_rst_i, .cfg_present_i, .cfg_valid_i, .cfg_by_originator_i,
        .cfg_locked_i, .configuring_i, .field_pwr_present_i, .field_pwr_in_limits_i,
        .sensor_pwr_used_i, .sensor_over_i, .sensor_under_i, .ain_used_i, .ain_fault_i,
        .ain_partner_fault_i, .ain_tach_mode_i, .ain_tach_above_on_i, .ain_tach_below_off_i,
        .din_on_i, .din_fault_i, .din_partner_fault_i, .dout_cmd_i, .dout_fault_i,
        .dout_partner_fault_i, .dout_dual_i, .config_lock_indicator_o, .field_power_indicator_o,
        .sensor_supply_indicators_o, .ain_indicator_o, .din_indicator_o, .dout_indicator_o
    );
    sio_lamp_reader reader (
        .clock_i, .clear_i(clear), .lamp_i(watch), .lit_o(lit), .dark_o(dark), .hue_o(hue)
    );
    assign watch = sel == 0 ? config_lock_indicator_o : sel == 1 ? din_indicator_o[0] :
        sel == 2 ? ain_indicator_o[0] : dout_indicator_o[0];

    always #10 clock_i = ~clock_i;

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) begin
            @(posedge clock_i);
            #2;
        end
    endtask

    function automatic void lamp(int k, logic f, logic p, logic on, sio_color_e c);
        ex[k] = (f | p) ? SIO_RED : (on ? c : SIO_OFF);
        fx[k] = !f & p;
    endfunction

    task automatic note(logic [2:0] kind);
        notes.push_back('{kind, ex, fx});
        -> look;
        ex = {8{SIO_OFF}};
        fx = 8'h00;
    endtask

    // Flashing lamps may be seen in either half, so dark passes there
    task automatic cmp_lamp(logic [2:0] kind, int k, sio_color_e e, logic fl, sio_color_e s);
        checks++;
        if (!((s === e) || (fl && s === SIO_OFF))) begin
            errors++;
            $display("CHECK FAILED lamp %0d[%0d] expected %0d seen %0d", kind, k, e, s);
        end
    endtask

    task automatic cmp_count(string what, logic [7:0] e, logic [7:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, e, s);
        end
    endtask

    initial begin : monitor
        sio_note_s n;
        sio_color_e [7:0] seen;
        forever begin
            @(look);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                seen = {8{SIO_OFF}};
                case (n.kind)
                    3'd0: seen[0] = config_lock_indicator_o;
                    3'd1: seen[0] = field_power_indicator_o;
                    3'd2: seen[3:0] = sensor_supply_indicators_o;
                    3'd3: seen[3:0] = ain_indicator_o;
                    3'd4: seen = din_indicator_o;
                    3'd5: seen = dout_indicator_o;
                    default: seen[0] = hue;
                endcase
                if (n.kind == 3'd6) begin
                    cmp_count("lit", 8'(2 * HALF), lit);
                    cmp_count("dark", 8'(2 * HALF), dark);
                end
                for (int k = 0; k < 8; k++) begin
                    cmp_lamp(n.kind, k, n.exp[k], n.fl[k], seen[k]);
                end
            end
        end
    end

    task automatic rand_step();
        {cfg_present_i, cfg_valid_i, cfg_by_originator_i, cfg_locked_i} = 4'($random(seed));
        {configuring_i, field_pwr_present_i, field_pwr_in_limits_i} = 3'($random(seed));
        {sensor_pwr_used_i, sensor_over_i, sensor_under_i} = 12'($random(seed));
        {ain_used_i, din_on_i, dout_cmd_i, dout_dual_i} = 24'($random(seed));
        ain_fault_i = 4'($random(seed) & $random(seed));
        ain_partner_fault_i = 4'($random(seed) & $random(seed));
        din_fault_i = 8'($random(seed) & $random(seed));
        din_partner_fault_i = 8'($random(seed) & $random(seed));
        dout_fault_i = 8'($random(seed) & $random(seed));
        dout_partner_fault_i = 8'($random(seed));
        tick(1);
        ex[0] = (!cfg_present_i | !cfg_valid_i | cfg_by_originator_i) ? SIO_OFF : SIO_YELLOW;
        fx[0] = !cfg_locked_i;
        note(3'd0);
        for (int k = 0; k < 4; k++) begin
            lamp(k, sensor_pwr_used_i[k] & (sensor_over_i[k] | sensor_under_i[k]), 1'b0,
                sensor_pwr_used_i[k], SIO_GREEN);
            lamp(k + 4, ain_fault_i[k], ain_partner_fault_i[k], ain_used_i[k] & !configuring_i,
                SIO_YELLOW);
        end
        sf = |(sensor_pwr_used_i & (sensor_over_i | sensor_under_i));
        ex[3:0] = ex[7:4];
        ex[7:4] = {4{SIO_OFF}};
        fx = {4'h0, fx[7:4]};
        note(3'd3);
        for (int k = 0; k < 4; k++) begin
            lamp(k, sensor_pwr_used_i[k] & (sensor_over_i[k] | sensor_under_i[k]), 1'b0,
                sensor_pwr_used_i[k], SIO_GREEN);
        end
        note(3'd2);
        ex[0] = !field_pwr_present_i ? SIO_OFF :
            ((!field_pwr_in_limits_i | sf) ? SIO_YELLOW : SIO_GREEN);
        note(3'd1);
        for (int k = 0; k < 8; k++) begin
            lamp(k, din_fault_i[k], din_partner_fault_i[k], din_on_i[k] & !configuring_i,
                SIO_YELLOW);
        end
        note(3'd4);
        for (int k = 0; k < 8; k++) begin
            lamp(k, dout_fault_i[k] | (dout_dual_i[k / 2] &
                (dout_cmd_i[2 * (k / 2)] != dout_cmd_i[2 * (k / 2) + 1])),
                dout_partner_fault_i[k] & dout_dual_i[k / 2], dout_cmd_i[k] & !configuring_i,
                SIO_YELLOW);
        end
        note(3'd5);
    endtask

    task automatic flash(int s, sio_color_e c);
        sel = s;
        clear = 1'b1;
        tick(1);
        clear = 1'b0;
        tick(4 * HALF);
        ex[0] = c;
        note(3'd6);
    endtask

    initial begin
        #1000000;
        errors++;
        complete_run();
    end

    initial begin
        tick(5);
        for (int q = 0; q < 6; q++) begin
            note(3'(q));
        end
        tick(1);
        sys_rst_i = 1'b0;
        $display("test reset done");
        repeat (40) rand_step();
        $display("test random done");
        {cfg_present_i, cfg_valid_i, cfg_by_originator_i, cfg_locked_i} = 4'hc;
        {configuring_i, ain_used_i, ain_fault_i, ain_partner_fault_i} = 13'h0001;
        {din_fault_i, din_partner_fault_i, dout_fault_i, dout_partner_fault_i} = 32'h00010001;
        dout_dual_i = 4'h1;
        dout_cmd_i = 8'h00;
        tick(4);
        flash(0, SIO_YELLOW);
        flash(1, SIO_RED);
        flash(2, SIO_RED);
        flash(3, SIO_RED);
        $display("test flash done");
        {ain_used_i, ain_partner_fault_i, ain_tach_mode_i, ain_tach_below_off_i} = 16'h1011;
        tick(12);
        note(3'd3);
        {ain_tach_above_on_i, ain_tach_below_off_i} = 8'h10;
        tick(2);
        ex[0] = SIO_YELLOW;
        note(3'd3);
        {ain_tach_above_on_i, ain_tach_below_off_i} = 8'h01;
        tick(3);
        ex[0] = SIO_YELLOW;
        note(3'd3);
        tick(12);
        note(3'd3);
        $display("test tach done");
        complete_run();
    end
endmodule
`default_nettype wire
